/* core/tec_pkg.sv */
// package for the timer/event counter: register map, fields, reset values
// assumes a single 200 MHz clock and a plain strobe register port
package tec_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFF_MODE = 12'hfa0;
  localparam logic [11:0] OFF_OUTEN = 12'hfa4;
  localparam logic [11:0] OFF_MODULO = 12'hfa8;
  localparam logic [11:0] OFF_COUNT = 12'hfac;
  localparam logic [11:0] OFF_STATUS = 12'hfb0;
  localparam logic [11:0] OFF_MASK = 12'hfb4;
  localparam int unsigned BIT_ENABLE = 2;
  localparam int unsigned BIT_START = 3;
  localparam int unsigned SEL_LO = 4;
  localparam int unsigned SEL_HI = 6;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] MODULO_RST = 8'hff;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] SEL_RISE = 3'h0;
  localparam logic [2:0] SEL_FALL = 3'h1;
  localparam logic [2:0] SEL_DIV1024 = 3'h4;
  localparam logic [2:0] SEL_DIV256 = 3'h5;
  localparam logic [2:0] SEL_DIV64 = 3'h6;
  localparam logic [2:0] SEL_DIV16 = 3'h7;
  localparam int unsigned PRESCALE_W = 10;
  localparam int unsigned STATUS_MATCH = 0;
endpackage

/* core/tec_prescaler.sv */
// free-running prescaler giving one-cycle ticks at clk/1024, 256, 64, 16
// assumes it shares clk, srst and ce with the counter core
`default_nettype none
module tec_prescaler
  import tec_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  output logic [3:0] tick
);
  typedef struct packed {
    logic [PRESCALE_W-1:0] cnt;
    logic [3:0] tick;
  } pre_state_t;
  pre_state_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 1'b1;
    // tick on the last count of each power-of-two span
    s_d.tick[0] = &s_q.cnt[9:0];
    s_d.tick[1] = &s_q.cnt[7:0];
    s_d.tick[2] = &s_q.cnt[5:0];
    s_d.tick[3] = &s_q.cnt[3:0];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign tick = ce ? s_q.tick : 4'h0;
endmodule
`default_nettype wire

/* core/timer_event_counter.sv */
// 8-bit timer/event counter with modulo compare, toggle output and irq
// assumes one clock domain; the event pin is asynchronous and synchronised
`default_nettype none
module timer_event_counter
  import tec_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [tec_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic event_input_pin,
  output logic square_wave_out_pin,
  output logic square_wave_out_oe,
  output logic irq
);
  import tec_pkg::*;

  typedef struct packed {
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic [7:0] count_mode_control;
    logic square_out_enable_flag;
    logic toggle_output_flop;
    logic [7:0] interval_modulo_reg;
    logic [7:0] count_value_reg;
    logic counter_irq_flag;
    logic irq_mask;
    logic [7:0] rdata;
  } state_t;

  state_t s_q, s_d;
  logic [3:0] tick;
  logic count_pulse;
  logic match;
  logic start_wr;
  logic [2:0] sel;

  tec_prescaler u_pre (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .tick(tick)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  assign sel = s_q.count_mode_control[SEL_HI:SEL_LO];
  assign start_wr = wr && hit(addr, OFF_MODE) && wdata[BIT_START];

  always_comb begin
    case (sel)
      SEL_RISE: count_pulse = s_q.ev_s2 & ~s_q.ev_s3;
      SEL_FALL: count_pulse = ~s_q.ev_s2 & s_q.ev_s3;
      SEL_DIV1024: count_pulse = tick[0];
      SEL_DIV256: count_pulse = tick[1];
      SEL_DIV64: count_pulse = tick[2];
      SEL_DIV16: count_pulse = tick[3];
      // prohibited codes give no pulses rather than undefined counting
      default: count_pulse = 1'b0;
    endcase
  end

  // gated pulse: withheld while the enable bit is low
  logic cp_en;
  assign cp_en = count_pulse && s_q.count_mode_control[BIT_ENABLE];
  assign match = cp_en && (s_q.count_value_reg == s_q.interval_modulo_reg);

  always_comb begin
    s_d = s_q;
    s_d.ev_s1 = event_input_pin;
    s_d.ev_s2 = s_q.ev_s1;
    s_d.ev_s3 = s_q.ev_s2;
    // start bit clears itself one cycle after it is written
    s_d.count_mode_control[BIT_START] = 1'b0;
    if (cp_en) begin
      if (match) begin
        s_d.count_value_reg = COUNT_RST;
        s_d.toggle_output_flop = ~s_q.toggle_output_flop;
        s_d.counter_irq_flag = 1'b1;
      end else begin
        s_d.count_value_reg = s_q.count_value_reg + 8'h01;
      end
    end
    s_d.rdata = 8'h00;
    if (rd) begin
      if (hit(addr, OFF_MODE)) s_d.rdata = s_q.count_mode_control;
      else if (hit(addr, OFF_OUTEN))
        s_d.rdata = {7'h00, s_q.square_out_enable_flag};
      else if (hit(addr, OFF_MODULO)) s_d.rdata = s_q.interval_modulo_reg;
      else if (hit(addr, OFF_COUNT)) s_d.rdata = s_q.count_value_reg;
      else if (hit(addr, OFF_STATUS))
        s_d.rdata = {6'h00, s_q.ev_s2, s_q.counter_irq_flag};
      else if (hit(addr, OFF_MASK)) s_d.rdata = {7'h00, s_q.irq_mask};
      // read of status clears the flag unless a match sets it now
      if (hit(addr, OFF_STATUS) && !match) s_d.counter_irq_flag = 1'b0;
    end
    if (wr) begin
      if (hit(addr, OFF_MODE)) begin
        s_d.count_mode_control = wdata;
        if (wdata[BIT_START]) begin
          // restart wins over a coincident match
          s_d.count_value_reg = COUNT_RST;
          s_d.counter_irq_flag = 1'b0;
          s_d.toggle_output_flop = 1'b0;
        end
      end
      if (hit(addr, OFF_OUTEN)) s_d.square_out_enable_flag = wdata[0];
      // modulo writable in any mode; zero is left to software to avoid
      if (hit(addr, OFF_MODULO)) s_d.interval_modulo_reg = wdata;
      if (hit(addr, OFF_STATUS)) begin
        // software may set or clear the flag; a match still wins a clear
        s_d.counter_irq_flag = wdata[STATUS_MATCH] | match;
      end
      if (hit(addr, OFF_MASK)) s_d.irq_mask = wdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.count_mode_control <= MODE_RST;
      s_q.interval_modulo_reg <= MODULO_RST;
      s_q.square_out_enable_flag <= 1'b0;
      s_q.toggle_output_flop <= 1'b0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign square_wave_out_pin = s_q.toggle_output_flop;
  assign square_wave_out_oe = s_q.square_out_enable_flag;
  assign irq = s_q.counter_irq_flag & s_q.irq_mask;

  // checks
  logic past_valid_q;
  always_ff @(posedge clk) begin
    if (srst) past_valid_q <= 1'b0;
    else past_valid_q <= 1'b1;
  end

  chk_start_self_clear: assert property (@(posedge clk) disable iff (srst)
    ce && start_wr ##1 ce |=> !s_q.count_mode_control[BIT_START])
    else $error("start bit did not clear");
  chk_start_clears: assert property (@(posedge clk) disable iff (srst)
    ce && start_wr |=> s_q.count_value_reg == 8'h00 && !s_q.counter_irq_flag)
    else $error("start did not clear count and flag");
  chk_start_tout: assert property (@(posedge clk) disable iff (srst)
    ce && start_wr |=> !s_q.toggle_output_flop)
    else $error("start did not clear toggle flop");
  chk_reset_values: assert property (@(posedge clk)
    srst |=> s_q.count_mode_control == 8'h00 && !square_wave_out_oe
      && !square_wave_out_pin)
    else $error("reset values wrong");
  chk_oe_follows: assert property (@(posedge clk) disable iff (srst)
    square_wave_out_oe == s_q.square_out_enable_flag)
    else $error("output enable mismatch");
  chk_toggle_match: assert property (@(posedge clk) disable iff (srst)
    ce && match && !wr |=> square_wave_out_pin != $past(square_wave_out_pin))
    else $error("toggle flop did not invert on match");
  chk_hold_stopped: assert property (@(posedge clk) disable iff (srst)
    ce && !s_q.count_mode_control[BIT_ENABLE] && !wr
      |=> $stable(s_q.count_value_reg))
    else $error("count moved while stopped");
  chk_advance: assert property (@(posedge clk) disable iff (srst)
    ce && cp_en && !match && !wr
      |=> s_q.count_value_reg == $past(s_q.count_value_reg) + 8'h01)
    else $error("count did not advance");
  chk_wrap_irq: assert property (@(posedge clk) disable iff (srst)
    ce && match && !wr |=> s_q.count_value_reg == 8'h00
      && s_q.counter_irq_flag)
    else $error("match did not wrap and flag");
  chk_read_latency: assert property (@(posedge clk) disable iff (srst)
    ce && rd && hit(addr, OFF_COUNT) |=> rdata == $past(s_q.count_value_reg))
    else $error("count read wrong");

  cov_match: cover property (@(posedge clk) disable iff (srst) match);
  cov_start: cover property (@(posedge clk) disable iff (srst) start_wr);
  cov_irq: cover property (@(posedge clk) disable iff (srst) irq);
  cov_event: cover property (@(posedge clk) disable iff (srst)
    cp_en && sel == SEL_RISE);
endmodule
`default_nettype wire

/* dv/tec_event_src.sv */
// partner model: external event pulse source on the event input pin
// assumes the bench calls pulse() from its main thread, clocked by clk
`default_nettype none
module tec_event_src (
  input wire logic clk,
  output logic event_input_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial event_input_pin = 1'b0;
  // 4 high, 4 low: wider than the 3-cycle synchroniser path
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge clk) event_input_pin <= 1'b1;
      repeat (4) @(posedge clk);
      event_input_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* dv/timer_event_counter_test.sv */
// testbench for the timer/event counter: register tasks and sequences
// assumes tec_pkg and tec_event_src are compiled first
`default_nettype none
module timer_event_counter_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tec_pkg::*;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00, rdata;
  logic pin, oe, irq, ev;
  int miscompares = 0, checked = 0;
  int n;
  always #2.5 clk = ~clk;
  timer_event_counter i_timer_event_counter (.clk(clk), .srst(srst),
    .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .event_input_pin(ev), .square_wave_out_pin(pin),
    .square_wave_out_oe(oe), .irq(irq));
  tec_event_src i_tec_event_src (.clk(clk), .event_input_pin(ev));
  task automatic report_and_stop();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic wait_pin(output int c);
    logic p;
    // let the edge that launched the last write settle before sampling
    #1;
    p = pin;
    c = 0;
    while (pin === p && c < 5000) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (c >= 5000) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // first toggle after start may be short: the prescaler runs free
  task automatic meas(input logic [2:0] code, input int div);
    int c;
    wreg(OFF_MODULO, 8'h01);
    wreg(OFF_MODE, {1'b0, code, 4'hc});
    wait_pin(c);
    wait_pin(c);
    chk(16'(c), 16'(2 * div));
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({13'h0, pin, oe, irq}, 16'h0000);
    rchk(OFF_MODE, MODE_RST);
    rchk(OFF_OUTEN, 8'h00);
    rchk(OFF_MODULO, MODULO_RST);
    rchk(OFF_COUNT, COUNT_RST);
    rchk(OFF_STATUS, 8'h00);
    rchk(12'hfbc, 8'h00);
    wreg(OFF_MODULO, 8'h02);
    wreg(OFF_MASK, 8'h01);
    wreg(OFF_OUTEN, 8'h01);
    wreg(OFF_MODE, 8'h0c);
    rchk(OFF_MODE, 8'h04);
    i_tec_event_src.pulse(2);
    rchk(OFF_COUNT, 8'h02);
    chk({15'h0, irq}, 16'h0000);
    i_tec_event_src.pulse(1);
    rchk(OFF_COUNT, 8'h00);
    chk({13'h0, pin, oe, irq}, 16'h0007);
    rchk(OFF_STATUS, 8'h01);
    chk({15'h0, irq}, 16'h0000);
    wreg(OFF_OUTEN, 8'h00);
    i_tec_event_src.pulse(1);
    rchk(OFF_COUNT, 8'h01);
    chk({14'h0, pin, oe}, 16'h0002);
    wreg(OFF_MODE, 8'h00);
    i_tec_event_src.pulse(2);
    rchk(OFF_COUNT, 8'h01);
    wreg(OFF_STATUS, 8'h01);
    rchk(OFF_MASK, 8'h01);
    chk({15'h0, irq}, 16'h0001);
    wreg(OFF_MASK, 8'h00);
    rchk(OFF_MASK, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    wreg(OFF_MASK, 8'h01);
    wreg(OFF_MODE, 8'h0c);
    rchk(OFF_COUNT, 8'h00);
    rchk(OFF_STATUS, 8'h00);
    chk({15'h0, pin}, 16'h0000);
    wreg(OFF_MODE, 8'h1c);
    i_tec_event_src.pulse(1);
    rchk(OFF_COUNT, 8'h01);
    wreg(OFF_MODE, 8'h2c);
    i_tec_event_src.pulse(2);
    rchk(OFF_COUNT, 8'h00);
    // clock enable low freezes the synchroniser, so the pulse is not seen
    wreg(OFF_MODE, 8'h0c);
    @(posedge clk);
    ce <= 1'b0;
    i_tec_event_src.pulse(1);
    ce <= 1'b1;
    rchk(OFF_COUNT, 8'h00);
    i_tec_event_src.pulse(1);
    rchk(OFF_COUNT, 8'h01);
    for (int i = 0; i < 4; i++) begin
      meas(3'(4 + i), 1024 >> (2 * i));
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
